// ### logic/node_config_defines.vh
// Constants for the RS-485 node configuration and framing detection block.
// Assumes inclusion by bare name from the logic/ design files.
`ifndef NODE_CONFIG_DEFINES_VH
`define NODE_CONFIG_DEFINES_VH

`define CLK_HZ          32'd100000000
`define BAUD_9600       20'd9600
`define BAUD_19200      20'd19200
`define BAUD_38400      20'd38400
`define BAUD_57600      20'd57600
`define BAUD_76800      20'd76800
`define BAUD_115200     20'd115200
`define BACNET_ADDR_MIN 8'h00
`define BACNET_ADDR_MAX 8'h7f
`define MODBUS_ADDR_MIN 8'h01
`define MODBUS_ADDR_MAX 8'hf7
`define FACTORY_ADDR    8'h7f
// Option switch bit positions (position 1 is bit 0)
`define OPT_MENU_BIT    0
`define OPT_PROTO_BIT   1
// Parity codes
`define PAR_NONE        2'h0
`define PAR_EVEN        2'h1
`define PAR_ODD         2'h2
// Framing candidate index: 0 is BACnet, 1..15 are Modbus (5 rates x 3 framings)
`define CAND_BACNET     4'h0
`define CAND_LAST       4'hf
// Text label codes for the display
`define LBL_NONE        3'h0
`define LBL_ADDR        3'h1
`define LBL_ERR         3'h2
`define LBL_BACNET      3'h3
`define LBL_MODBUS      3'h4
// Display modes
`define DSP_BOOT        2'h0
`define DSP_HOME        2'h1
`define DSP_MENU        2'h2
// Modbus function read input registers
`define FC_READ_INPUT   8'h04
// AXI4-Lite register byte offsets
`define REG_STATUS      4'h0
`define REG_FRAMING     4'h4
`define REG_HOME        4'h8
`define REG_CONTROL     4'hc
`define AXI_OKAY        2'h0
`define AXI_SLVERR      2'h2

`endif

// ### logic/sync3.v
// Three-stage synchroniser with agreement filter for one pin input.
// Assumes a slowly changing level from outside the aclk domain.
`timescale 1ns/1ns
`default_nettype none
module sync3
(
  input  wire aclk,
  input  wire aresetn,
  input  wire pin,
  input  wire init,
  output reg  level
);
  reg s1;
  reg s2;
  reg s3;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      // Start at the pin's idle level so no false edge follows reset
      s1    <= init;
      s2    <= init;
      s3    <= init;
      level <= init;
    end
    else
    begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      // Change counts only once stages two and three agree
      if (s2 == s3)
        level <= s3;
    end
  end
endmodule // sync3
`default_nettype wire

// ### logic/frame_rx.v
// Serial receiver for one trial framing: start, 8 data, optional parity, stop bits.
// Assumes a synchronised rx level and a divider chosen by the caller.
`timescale 1ns/1ns
`default_nettype none
`include "node_config_defines.vh"
module frame_rx
#(
  parameter DIV_W = 14
)
(
  input  wire             aclk,
  input  wire             aresetn,
  input  wire             rx,
  input  wire [DIV_W-1:0] bit_div,
  input  wire [1:0]       parity,
  input  wire             two_stop,
  output reg  [7:0]       data,
  output reg              data_valid,
  output reg              frame_err
);
  localparam ST_IDLE  = 2'd0;
  localparam ST_START = 2'd1;
  localparam ST_BITS  = 2'd2;
  localparam ST_STOP  = 2'd3;

  reg [1:0]       state;
  reg [DIV_W-1:0] cnt;
  reg [3:0]       bit_idx;
  reg [8:0]       shift;
  reg             stop2;
  wire [3:0]      nbits = (parity == `PAR_NONE) ? 4'd8 : 4'd9;
  wire            tick = (cnt == {DIV_W{1'b0}});
  wire            par_ok = (parity == `PAR_NONE) ||
                           ((^shift) == (parity == `PAR_ODD));

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state      <= ST_IDLE;
      cnt        <= {DIV_W{1'b0}};
      bit_idx    <= 4'd0;
      shift      <= 9'h000;
      stop2      <= 1'b0;
      data       <= 8'h00;
      data_valid <= 1'b0;
      frame_err  <= 1'b0;
    end
    else
    begin
      data_valid <= 1'b0;
      frame_err  <= 1'b0;
      if (!tick)
        cnt <= cnt - 1'b1;
      case (state)
        ST_IDLE:
        begin
          if (!rx)
          begin
            cnt   <= {1'b0, bit_div[DIV_W-1:1]};
            state <= ST_START;
          end
        end
        ST_START:
        begin
          if (tick)
          begin
            cnt     <= bit_div;
            bit_idx <= 4'd0;
            state   <= rx ? ST_IDLE : ST_BITS;
          end
        end
        ST_BITS:
        begin
          if (tick)
          begin
            cnt     <= bit_div;
            shift   <= {rx, shift[8:1]};
            bit_idx <= bit_idx + 1'b1;
            if (bit_idx == nbits - 1'b1)
            begin
              stop2 <= two_stop;
              state <= ST_STOP;
            end
          end
        end
        ST_STOP:
        begin
          if (tick)
          begin
            cnt <= bit_div;
            if (!rx || !par_ok)
            begin
              frame_err <= 1'b1;
              state     <= ST_IDLE;
            end
            else if (stop2)
              stop2 <= 1'b0;
            else
            begin
              data       <= (parity == `PAR_NONE) ? shift[8:1] : shift[7:0];
              data_valid <= 1'b1;
              state      <= ST_IDLE;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule // frame_rx
`default_nettype wire

// ### logic/node_config.v
// Node configuration: switch address, protocol, menu gating, framing detection,
// AXI4-Lite status registers. Assumes a slow non-volatile store handshake
// and a message checker outside that reports good frames for our address.
`timescale 1ns/1ns
`default_nettype none
`include "node_config_defines.vh"
module node_config
#(
  parameter DIV_W         = 14,
  parameter SILENCE_BITS  = 40
)
(
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  address_switch_bank,
  input  wire [3:0]  option_switch_bank,
  input  wire        rx_pin,
  input  wire        display_present,
  input  wire        menu_request,
  input  wire        msg_own_ok,
  input  wire        nvm_valid,
  input  wire [3:0]  nvm_framing,
  input  wire        nvm_done,
  output reg         nvm_write,
  output reg  [3:0]  nvm_wdata,
  output reg  [7:0]  node_address,
  output reg         address_valid,
  output reg         protocol_modbus,
  output reg         framing_locked,
  output reg  [19:0] baud_rate,
  output reg  [1:0]  parity_mode,
  output reg         two_stop_bits,
  output reg         rx_byte_valid,
  output reg  [7:0]  rx_byte,
  output reg         respond_enable,
  output reg         menu_active,
  output reg  [1:0]  display_mode,
  output reg  [7:0]  primary_value,
  output reg  [2:0]  primary_text,
  output reg  [2:0]  secondary_text,
  output reg  [3:0]  home_select,
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);
  localparam ST_BOOT   = 3'd0;
  localparam ST_NVM    = 3'd1;
  localparam ST_DETECT = 3'd2;
  localparam ST_STORE  = 3'd3;
  localparam ST_RUN    = 3'd4;
  localparam ST_HALT   = 3'd5;

  wire        rx;
  wire [7:0]  rx_data;
  wire        rx_dv;
  wire        rx_err;
  reg  [2:0]  state;
  reg  [3:0]  cand;
  reg         sw_seen;
  reg  [3:0]  good_bytes;
  reg  [7:0]  sw_addr;
  reg         sw_modbus;
  reg         sw_valid;
  reg  [1:0]  home_sel_cfg;
  reg         boot_shown;

  sync3 u_rx_sync
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin     (rx_pin),
    .init    (1'b1),
    .level   (rx)
  );

  // Candidate table: 0 is BACnet, then Modbus rate-major, framing-minor
  function [19:0] cand_baud;
    input [3:0] c;
    reg   [3:0] r;
    begin
      r = (c - 4'd1) / 4'd3;
      case (r)
        4'd0:    cand_baud = `BAUD_19200;
        4'd1:    cand_baud = `BAUD_38400;
        4'd2:    cand_baud = `BAUD_57600;
        4'd3:    cand_baud = `BAUD_76800;
        default: cand_baud = `BAUD_115200;
      endcase
      if (c == `CAND_BACNET)
        cand_baud = `BAUD_9600;
    end
  endfunction

  function [2:0] cand_frame;
    input [3:0] c;
    reg   [3:0] f;
    begin
      f = (c - 4'd1) % 4'd3;
      case (f)
        4'd0:    cand_frame = {`PAR_EVEN, 1'b0};
        4'd1:    cand_frame = {`PAR_ODD, 1'b0};
        default: cand_frame = {`PAR_NONE, 1'b1};
      endcase
      if (c == `CAND_BACNET)
        cand_frame = {`PAR_NONE, 1'b0};
    end
  endfunction

  wire [19:0]      c_baud = cand_baud(cand);
  wire [2:0]       c_frame = cand_frame(cand);
  wire [31:0]      div32 = `CLK_HZ / c_baud;
  wire [DIV_W-1:0] c_div = div32[DIV_W-1:0] - 1'b1;

  frame_rx #(.DIV_W(DIV_W)) u_rx
  (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .rx         (rx),
    .bit_div    (c_div),
    .parity     (c_frame[2:1]),
    .two_stop   (c_frame[0]),
    .data       (rx_data),
    .data_valid (rx_dv),
    .frame_err  (rx_err)
  );

  // Switch decode is combinational from the raw switch inputs; the results are registered below
  wire [7:0] addr_now = address_switch_bank; // bit7 = position 1, weight 128
  wire       modbus_now = option_switch_bank[`OPT_PROTO_BIT];
  wire       valid_now = modbus_now ?
               (addr_now >= `MODBUS_ADDR_MIN && addr_now <= `MODBUS_ADDR_MAX) :
               (addr_now <= `BACNET_ADDR_MAX);

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      // Factory address until the switches are sampled
      sw_addr   <= `FACTORY_ADDR;
      sw_modbus <= 1'b0;
      // Not valid until sampled, so no stale address is ever flagged valid
      sw_valid  <= 1'b0;
      sw_seen   <= 1'b0;
    end
    else
    begin
      sw_seen   <= 1'b1;
      sw_addr   <= addr_now;
      sw_modbus <= modbus_now;
      sw_valid  <= valid_now;
    end
  end

  // Detection state machine; only reset (power cycle) returns to boot
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state      <= ST_BOOT;
      cand       <= `CAND_BACNET;
      good_bytes <= 4'h0;
      nvm_write  <= 1'b0;
      nvm_wdata  <= 4'h0;
      framing_locked <= 1'b0;
    end
    else
    begin
      nvm_write <= 1'b0;
      case (state)
        ST_BOOT:
        begin
          // Decide only once the switches have been sampled
          if (sw_seen)
            state <= !sw_valid ? ST_HALT : (nvm_valid ? ST_NVM : ST_DETECT);
        end
        ST_NVM:
        begin
          // Stored framing is the default at start-up
          cand  <= nvm_framing;
          state <= ST_RUN;
        end
        ST_DETECT:
        begin
          if (!sw_modbus)
            cand <= `CAND_BACNET;
          else if (cand == `CAND_BACNET)
            cand <= 4'h1;
          if (rx_err)
          begin
            good_bytes <= 4'h0;
            // Try next framing of this protocol on any framing error
            if (sw_modbus)
              cand <= (cand == `CAND_LAST) ? 4'h1 : cand + 4'h1;
          end
          else if (rx_dv && good_bytes != 4'hf)
            good_bytes <= good_bytes + 4'h1;
          // Lock only on a verified message to our own address
          if (msg_own_ok && good_bytes != 4'h0)
          begin
            nvm_wdata <= cand;
            nvm_write <= 1'b1;
            state     <= ST_STORE;
          end
        end
        ST_STORE:
        begin
          if (nvm_done)
            state <= ST_RUN;
          else
            nvm_write <= 1'b1;
        end
        // Framing changes on the line are ignored from here on
        ST_RUN:
        begin
          // Lock on the same edge as, or after, the framing outputs take the final candidate
          framing_locked <= 1'b1;
          state          <= ST_RUN;
        end
        ST_HALT: state <= ST_HALT;
        default: state <= ST_BOOT;
      endcase
    end
  end

  // Link-facing outputs
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      node_address    <= `FACTORY_ADDR;
      address_valid   <= 1'b0;
      protocol_modbus <= 1'b0;
      baud_rate       <= `BAUD_9600;
      parity_mode     <= `PAR_NONE;
      two_stop_bits   <= 1'b0;
      rx_byte_valid   <= 1'b0;
      rx_byte         <= 8'h00;
      respond_enable  <= 1'b0;
    end
    else
    begin
      node_address    <= sw_addr;
      address_valid   <= sw_valid;
      protocol_modbus <= sw_modbus;
      baud_rate       <= c_baud;
      parity_mode     <= c_frame[2:1];
      two_stop_bits   <= c_frame[0];
      rx_byte_valid   <= rx_dv && state != ST_HALT;
      rx_byte         <= rx_data;
      // No answers until locked, never with a bad address
      respond_enable  <= sw_valid && state == ST_RUN;
    end
  end

  // Display and menu
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      display_mode   <= `DSP_BOOT;
      primary_value  <= 8'h00;
      primary_text   <= `LBL_NONE;
      secondary_text <= `LBL_NONE;
      menu_active    <= 1'b0;
      home_select    <= 4'h0;
      boot_shown     <= 1'b0;
    end
    else
    begin
      // One slot: low two bits select the quantity, upper two bits zero, all zero without a display
      home_select <= {2'b00, home_sel_cfg} & {4{display_present}};
      menu_active <= menu_request && display_present &&
                     option_switch_bank[`OPT_MENU_BIT];
      if (!boot_shown)
      begin
        display_mode  <= `DSP_BOOT;
        primary_value <= sw_addr;
        primary_text  <= sw_valid ? `LBL_ADDR : `LBL_ERR;
        secondary_text <= sw_modbus ? `LBL_MODBUS : `LBL_BACNET;
        boot_shown    <= state != ST_BOOT && sw_valid;
      end
      else
      begin
        display_mode   <= menu_active ? `DSP_MENU : `DSP_HOME;
        primary_text   <= `LBL_NONE;
        secondary_text <= `LBL_NONE;
      end
    end
  end

  // AXI4-Lite slave: one write and one read at a time
  reg        aw_held;
  reg        w_held;
  reg [3:0]  aw_addr;
  reg [31:0] w_data;
  reg [3:0]  w_strb;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `AXI_OKAY;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 4'h0;
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
      home_sel_cfg  <= 2'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr       <= s_axi_awaddr;
        aw_held       <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        w_held       <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (aw_held && w_held && !s_axi_bvalid)
      begin
        s_axi_bvalid <= 1'b1;
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        if (aw_addr == `REG_HOME)
        begin
          s_axi_bresp <= `AXI_OKAY;
          if (w_strb[0])
            home_sel_cfg <= w_data[1:0];
        end
        else if (aw_addr == `REG_STATUS || aw_addr == `REG_FRAMING ||
                 aw_addr == `REG_CONTROL)
          s_axi_bresp <= `AXI_OKAY;
        else
          s_axi_bresp <= `AXI_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `AXI_OKAY;
    end
    else
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= `AXI_OKAY;
        case (s_axi_araddr)
          `REG_STATUS:
            s_axi_rdata <= {13'h0000, state, 5'h00, framing_locked, sw_modbus, sw_valid,
                            sw_addr};
          `REG_FRAMING:
            s_axi_rdata <= {cand, c_frame[0], c_frame[2:1], 5'h00, c_baud};
          `REG_HOME:
            s_axi_rdata <= {30'h00000000, home_sel_cfg};
          `REG_CONTROL:
            s_axi_rdata <= {28'h0000000, option_switch_bank};
          default:
          begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `AXI_SLVERR;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule // node_config
`default_nettype wire

// ### tb/node_config_checker.sv
// Concurrent checks on the node configuration ports.
// Assumes it is bound into node_config and sees its ports only.
`timescale 1ns/1ns
`default_nettype none
module node_config_checker
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  address_switch_bank,
  input wire logic [3:0]  option_switch_bank,
  input wire logic        display_present,
  input wire logic        nvm_done,
  input wire logic        nvm_write,
  input wire logic [7:0]  node_address,
  input wire logic        address_valid,
  input wire logic        protocol_modbus,
  input wire logic        framing_locked,
  input wire logic [19:0] baud_rate,
  input wire logic [1:0]  parity_mode,
  input wire logic        two_stop_bits,
  input wire logic        rx_byte_valid,
  input wire logic        respond_enable,
  input wire logic        menu_active
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_addr_weight: assert property (address_valid |-> node_address == address_switch_bank)
    else $error("node address differs from switch weights");
  a_bacnet_range: assert property (address_valid && !protocol_modbus |-> node_address <= 8'h7f)
    else $error("bacnet address out of range marked valid");
  a_modbus_range: assert property (address_valid && protocol_modbus |-> node_address inside {[8'h01:8'hf7]})
    else $error("modbus address out of range marked valid");
  a_proto_select: assert property (address_valid |-> protocol_modbus == option_switch_bank[1])
    else $error("protocol does not follow option switch");
  a_menu_gate: assert property (menu_active |-> $past(display_present && option_switch_bank[0]))
    else $error("menu active without switch and display");
  a_respond_gate: assert property (respond_enable |-> framing_locked && address_valid)
    else $error("responding before lock or with bad address");
  a_lock_stays: assert property (framing_locked |=> framing_locked)
    else $error("framing lock dropped without reset");
  a_store_hold: assert property (nvm_write && !nvm_done |=> nvm_write)
    else $error("store request released before done");
  a_bacnet_frame: assert property (framing_locked && !protocol_modbus |->
    baud_rate == 20'h02580 && parity_mode == 2'h0 && !two_stop_bits)
    else $error("bacnet framing not 9600 8N1");
  a_modbus_frame: assert property (framing_locked && protocol_modbus |-> baud_rate >= 20'h04b00
    && baud_rate <= 20'h1c200 && ((parity_mode == 2'h0) == two_stop_bits))
    else $error("modbus framing not a supported one");

  c_locked_modbus: cover property (framing_locked && protocol_modbus);
  c_menu: cover property (menu_active);
  c_rx_byte: cover property (rx_byte_valid && framing_locked);
endmodule // node_config_checker

bind node_config node_config_checker u_chk (.*);
`default_nettype wire

// ### tb/line_master.sv
// Bus master model: sends single framed bytes on the serial receive line.
// Assumes the line is biased idle high while the master is silent.
`timescale 1ns/1ns
`default_nettype none
module line_master
#(
  parameter int BIT_CYCLES = 868
)
(
  input  wire logic aclk,
  output var  logic line
);
  initial line = 1'b1;

  // Request traffic for detection; parity bit or second stop
  task automatic send_byte(input logic [7:0] d, input logic [1:0] par, input logic bad);
    logic [10:0] bits;
    bits = (par == 2'h0) ? {2'b11, d, 1'b0} : {1'b1, (par == 2'h2) ^ (^d) ^ bad, d, 1'b0};
    for (int i = 0; i < 11; i++)
    begin
      @(posedge aclk);
      line <= bits[i];
      repeat (BIT_CYCLES - 1) @(posedge aclk);
    end
  endtask
endmodule // line_master
`default_nettype wire

// ### tb/tb.sv
// Testbench for node_config: switch rows, stored framing, serial byte, registers.
// Assumes line_master on the receive line and the bound checker.
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  address_switch_bank = 8'h7f;
  logic [3:0]  option_switch_bank = 4'h0;
  logic        rx_pin;
  logic        display_present = 1'b1;
  logic        menu_request = 1'b1;
  logic        msg_own_ok = 1'b0;
  logic        nvm_valid = 1'b0;
  logic [3:0]  nvm_framing = 4'h0;
  logic        nvm_done = 1'b0;
  logic        nvm_write, address_valid, protocol_modbus, framing_locked, two_stop_bits;
  logic        rx_byte_valid, respond_enable, menu_active;
  logic [3:0]  nvm_wdata, home_select;
  logic [7:0]  node_address, rx_byte, primary_value;
  logic [19:0] baud_rate;
  logic [1:0]  parity_mode, display_mode, s_axi_bresp, s_axi_rresp, rs;
  logic [2:0]  primary_text, secondary_text;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  int          num_errors = 0;
  int          checks = 0;
  int          cycles = 0;
  localparam int nrows = 11;
  localparam logic [7:0] row_a [nrows] = '{8'h7f, 8'h80, 8'h00, 8'h00, 8'h01, 8'hf7,
                                           8'hf8, 8'h7f, 8'h80, 8'hc3, 8'h05};
  localparam logic [3:0] row_o [nrows] = '{4'h0, 4'h0, 4'h1, 4'h2, 4'h3, 4'h2,
                                           4'h2, 4'h2, 4'h3, 4'h2, 4'h2};
  localparam logic [3:0] row_c [nrows] = '{4'h0, 4'h0, 4'h0, 4'h1, 4'h1, 4'h5,
                                           4'h9, 4'h9, 4'ha, 4'hf, 4'h0};

  always #5 aclk = ~aclk;

  node_config u_dut (.*);
  line_master #(.BIT_CYCLES(868)) u_master (.aclk(aclk), .line(rx_pin));

  task automatic test_done();
    $display("Checks %0d, errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Two serial frames dominate the run time
  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 50000)
    begin
      num_errors = num_errors + 1;
      test_done();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Switches are sampled every cycle but the boot decision is made once, so every setting gets a reset
  task automatic cfg(input logic [7:0] a, input logic [3:0] o, input logic nv,
                     input logic [3:0] c);
    @(posedge aclk);
    aresetn <= 1'b0;
    address_switch_bank <= a;
    option_switch_bank <= o;
    nvm_valid <= nv;
    nvm_framing <= c;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (6) @(posedge aclk);
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  function automatic logic [22:0] frame_of(input logic [3:0] c);
    logic [19:0] rates [5];
    int          k;
    rates = '{20'h04b00, 20'h09600, 20'h0e100, 20'h12c00, 20'h1c200};
    if (c == 4'h0) return {1'b0, 2'h0, 20'h02580};
    k = int'(c) - 1;
    return {k % 3 == 2, (k % 3 == 0) ? 2'h1 : ((k % 3 == 1) ? 2'h2 : 2'h0), rates[k / 3]};
  endfunction

  initial
  begin
    logic md;
    logic ev;
    int   n;
    repeat (3) @(posedge aclk);
    chk({node_address, baud_rate}, {8'h7f, 20'h02580});
    for (int i = 0; i < nrows; i++)
    begin
      cfg(row_a[i], row_o[i], i < nrows - 1, row_c[i]);
      md = row_o[i][1];
      ev = md ? (row_a[i] >= 8'h01 && row_a[i] <= 8'hf7) : (row_a[i] <= 8'h7f);
      chk(node_address, row_a[i]);
      chk(address_valid, ev);
      chk(protocol_modbus, md);
      chk(menu_active, row_o[i][0]);
      chk(framing_locked, ev && i < nrows - 1);
      chk(respond_enable, ev && i < nrows - 1);
      if (!ev) chk({secondary_text, primary_text, primary_value},
                   {md ? 3'h4 : 3'h3, 3'h2, row_a[i]});
      chk(display_mode, !ev ? 2'h0 : (row_o[i][0] ? 2'h2 : 2'h1));
      if (ev && i < nrows - 1) chk({two_stop_bits, parity_mode, baud_rate}, frame_of(row_c[i]));
    end
    cfg(8'h01, 4'h3, 1'b1, 4'hd);
    display_present <= 1'b0;
    repeat (3) @(posedge aclk);
    chk(menu_active, 1'b0);
    display_present <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(menu_active, 1'b1);
    axi_rd(4'h0, rd, rs);
    chk({rs, rd[10:0]}, {2'h0, 11'h701});
    axi_rd(4'h4, rd, rs);
    chk(rd, {4'hd, 1'b0, 2'h1, 5'h0, 20'h1c200});
    axi_rd(4'hc, rd, rs);
    chk(rd[3:0], 4'h3);
    axi_wr(4'h8, 32'h2, rs);
    chk(rs, 2'h0);
    axi_rd(4'h8, rd, rs);
    chk({rs, rd[1:0], home_select}, {2'h0, 2'h2, 4'h2});
    axi_wr(4'h0, 32'hffffffff, rs);
    axi_rd(4'h0, rd, rs);
    chk({rs, rd[10:0]}, {2'h0, 11'h701});
    fork
      u_master.send_byte(8'ha5, 2'h1, 1'b0);
      begin
        n = 0;
        while (!rx_byte_valid && n < 15000)
        begin
          @(posedge aclk);
          n++;
        end
        chk({rx_byte_valid, rx_byte}, {1'b1, 8'ha5});
      end
    join
    u_master.send_byte(8'h3c, 2'h1, 1'b1);
    repeat (900) @(posedge aclk);
    chk({framing_locked, baud_rate}, {1'b1, 20'h1c200});
    msg_own_ok <= 1'b1;
    @(posedge aclk);
    msg_own_ok <= 1'b0;
    repeat (3) @(posedge aclk);
    chk(nvm_write, 1'b0);
    cfg(8'h05, 4'h2, 1'b0, 4'h0);
    msg_own_ok <= 1'b1;
    @(posedge aclk);
    msg_own_ok <= 1'b0;
    repeat (3) @(posedge aclk);
    chk({nvm_write, framing_locked}, 2'h0);
    test_done();
  end
endmodule // tb
`default_nettype wire
